// ---- srs_cfg.svh ----
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH

// register indices; byte address is four times the index
`define SRS_IDX_MODE      6'h00
`define SRS_IDX_FUNC      6'h01
`define SRS_IDX_TUNE      6'h02
`define SRS_IDX_SPD1      6'h08
`define SRS_IDX_SPD2      6'h09
`define SRS_IDX_SPD3      6'h0a
`define SRS_IDX_ACC       6'h0b
`define SRS_IDX_DEC       6'h0c
`define SRS_IDX_SCRV      6'h0d
`define SRS_IDX_STAT      6'h10
`define SRS_IDX_DROOP     6'h11
`define SRS_IDX_SPEED     6'h12

// reset values
`define SRS_RST_MODE      16'h0000
`define SRS_RST_FUNC      16'h0002
`define SRS_RST_TUNE      16'h0105
`define SRS_RST_SPD1      16'h0064
`define SRS_RST_SPD2      16'h01f4
`define SRS_RST_SPD3      16'h03e8
`define SRS_RST_ACC       16'h0000
`define SRS_RST_DEC       16'h0000
`define SRS_RST_SCRV      16'h0000

// field positions
`define SRS_MODE_SPEED_BIT 0
`define SRS_FUNC_FILT_MSB  3
`define SRS_FUNC_FILT_LSB  0
`define SRS_TUNE_LVL_MSB   3
`define SRS_TUNE_LVL_LSB   0

// bus answers
`define SRS_RESP_OKAY     2'h0
`define SRS_RESP_SLVERR   2'h2

// timing
`define SRS_CLK_MHZ       200
`define SRS_FILT_NS       3555000
`define SRS_MS_NS         1000000
`define SRS_DISP_MS       2000
`define SRS_RATED_RPM     3000

`endif

// ---- srs_pkg.sv ----
package srs_pkg;

   // filtered discrete inputs, one bit each
   typedef struct packed {
      logic servo_enable;
      logic fwd_travel_limit;
      logic rev_travel_limit;
      logic emergency_halt;
      logic fwd_run;
      logic rev_run;
      logic speed_pick1;
      logic speed_pick0;
   } srs_inputs_t;

   // run state of the output stage
   typedef enum logic [1:0] {
      SRS_UNPOWERED,
      SRS_COAST,
      SRS_LOCKED,
      SRS_BRAKED
   } srs_run_t;

   // drive outputs towards the power stage
   typedef struct packed {
      logic base_on;
      logic dyn_brake;
      logic servo_lock;
      logic brake_release;
   } srs_drive_t;

   // state of one input filter
   typedef struct packed {
      logic        meta;
      logic        sync;
      logic        stable;
      logic [23:0] cnt;
   } srs_filt_t;

endpackage

// ---- srs_in_filter.sv ----
`timescale 1ns/1ps
`default_nettype none

module srs_in_filter
   import srs_pkg::*;
#(
   parameter logic [23:0] FILT_CYC = 24'h0ad958
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic bypass,
   input  wire logic pin,
   output logic      filt
);

   srs_filt_t st;
   srs_filt_t next_st;

   // two-flop synchroniser, then a stability counter
   always_comb begin
      next_st      = st;
      next_st.meta = pin;
      next_st.sync = st.meta;
      if (bypass || st.sync == st.stable) begin
         next_st.cnt    = 24'h0;
         next_st.stable = st.sync;
      end else if (24'(st.cnt + 24'h1) >= FILT_CYC) begin
         next_st.cnt    = 24'h0;
         next_st.stable = st.sync; // RL16
      end else begin
         next_st.cnt = 24'(st.cnt + 24'h1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign filt = st.stable;

endmodule // srs_in_filter

`default_nettype wire

// ---- srs_sequencer.sv ----
// Notes on behaviour
// RL1: servo-on after power gives ready, motor locked
// RL2: controller powers up before raising servo-on
// RL3: servo-on is a contact to input common
// RL4: position mode follows the command pulse train
// RL5: servo-on off: output stage off, coasting
// RL6: alarm: output stage off, dynamic brake
// RL7: emergency off: brake, raise halt warning
// RL8: position limit: clear error, lock, reverse allowed
// RL9: speed limit: sudden stop, lock, reverse allowed
// RL10: both starts equal: ramped deceleration to stop
// RL11: sudden stop means zero deceleration time
// RL12: forward start counter-clockwise, reverse start clockwise
// RL13: speed picks choose stored speeds one to three
// RL14: ramps use accel, decel constants; S-curve zero
// RL15: mode and function writes apply after power cycle
// RL16: inputs filtered 3.555 ms, selected by function
// RL17: display shows symbol, value two seconds later
// RL18: gain tuning uses stored response level
// RL19: control mode valid only after power cycle
// RL20: alarm and emergency outrank limit, start stops
`include "srs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module srs_sequencer
   import srs_pkg::*;
#(
   parameter logic [23:0] FILT_CYC  = 24'(`SRS_FILT_NS * `SRS_CLK_MHZ / 1000),
   parameter logic [31:0] MS_CYC    = 32'(`SRS_MS_NS * `SRS_CLK_MHZ / 1000),
   parameter logic [31:0] DISP_CYC  = 32'(`SRS_DISP_MS * (`SRS_MS_NS / 1000) * `SRS_CLK_MHZ),
   parameter logic [15:0] RATED_RPM = 16'(`SRS_RATED_RPM)
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        power_good_in,
   input  wire logic        servo_enable_in,
   input  wire logic        fwd_travel_limit_in,
   input  wire logic        rev_travel_limit_in,
   input  wire logic        emergency_halt_in,
   input  wire logic        fwd_run_in,
   input  wire logic        rev_run_in,
   input  wire logic        speed_pick_bit0,
   input  wire logic        speed_pick_bit1,
   input  wire logic        cmd_pulse_in,
   input  wire logic        cmd_dir_in,
   input  wire logic        alarm_in,
   output srs_drive_t       drive,
   output logic             brake_interlock_out,
   output logic             halt_warning_code,
   output logic             motor_step,
   output logic             motor_dir,
   output logic [15:0]      speed_cmd,
   output logic [3:0]       tune_level,
   output logic             tune_active,
   output logic             display_speed_symbol,
   output logic             display_show_value
);

   typedef struct packed {
      logic               aw_held;
      logic               w_held;
      logic [5:0]         waddr;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [31:0]        rdata;
      logic [15:0]        mode_pend;
      logic [15:0]        func_pend;
      logic [15:0]        mode_act;
      logic [15:0]        func_act;
      logic [15:0]        tune;
      logic [15:0]        spd1;
      logic [15:0]        spd2;
      logic [15:0]        spd3;
      logic [15:0]        acc_tc;
      logic [15:0]        dec_tc;
      logic [15:0]        scrv_tc;
      logic               pwr_m;
      logic               pwr_s;
      logic               pwr_d;
      logic               pulse_m;
      logic               pulse_s;
      logic               pulse_d;
      logic               dir_m;
      logic               dir_s;
      srs_run_t           run;
      logic signed [15:0] droop;
      logic               step;
      logic               step_dir;
      logic signed [15:0] speed;
      logic [47:0]        ramp_acc;
      logic [31:0]        disp_cnt;
      logic               disp_value;
   } srs_state_t;

   srs_state_t         st;
   srs_state_t         next_st;
   srs_inputs_t        in;
   logic [7:0]         pin_vec;
   logic [7:0]         filt_vec;
   logic               filt_bypass;
   logic               speed_mode;
   logic               pwr_rise;
   logic               fwd_ok;
   logic               rev_ok;
   logic [14:0]        pick_mag;
   logic signed [15:0] target;
   logic signed [15:0] drp;
   logic               sudden;
   logic               accel;
   logic [15:0]        tc;
   logic [47:0]        thr;
   logic [47:0]        acc_sum;

   // discrete inputs in the order of the input struct
   assign pin_vec     = {servo_enable_in, fwd_travel_limit_in, rev_travel_limit_in, emergency_halt_in,
                         fwd_run_in, rev_run_in, speed_pick_bit1, speed_pick_bit0};
   assign filt_bypass = (st.func_act[`SRS_FUNC_FILT_MSB:`SRS_FUNC_FILT_LSB] == 4'h0);
   assign in          = srs_inputs_t'(filt_vec);

   // one synchronising filter per input
   for (genvar i = 0; i < 8; i++) begin : g_filt
      srs_in_filter #(
         .FILT_CYC (FILT_CYC)
      ) u_filt (
         .aclk    (aclk),
         .aresetn (aresetn),
         .bypass  (filt_bypass),
         .pin     (pin_vec[i]),
         .filt    (filt_vec[i])
      );
   end

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign speed_mode = st.mode_act[`SRS_MODE_SPEED_BIT];
   assign pwr_rise   = st.pwr_s && !st.pwr_d;
   assign fwd_ok     = in.fwd_travel_limit;
   assign rev_ok     = in.rev_travel_limit;

   // speed target from picks and start inputs
   always_comb begin
      unique case ({in.speed_pick1, in.speed_pick0})
         2'h0: pick_mag = 15'h0;
         2'h1: pick_mag = st.spd1[14:0]; // RL13
         2'h2: pick_mag = st.spd2[14:0]; // RL13
         2'h3: pick_mag = st.spd3[14:0]; // RL13
      endcase
      target = 16'sh0; // RL10
      if (in.fwd_run && !in.rev_run) begin
         target = $signed({1'b0, pick_mag}); // RL12
      end else if (in.rev_run && !in.fwd_run) begin
         target = 16'(-$signed({1'b0, pick_mag})); // RL12
      end
      sudden = (!fwd_ok && (target > 0 || st.speed > 0)) || (!rev_ok && (target < 0 || st.speed < 0));
      if (!fwd_ok && target > 0) begin
         target = 16'sh0; // RL9
      end
      if (!rev_ok && target < 0) begin
         target = 16'sh0; // RL9
      end
      accel = (target > 0 && target > st.speed && st.speed >= 0) ||
              (target < 0 && target < st.speed && st.speed <= 0);
      tc      = sudden ? 16'h0 : (accel ? st.acc_tc : st.dec_tc); // RL11 RL14
      thr     = {32'h0, tc} * {16'h0, MS_CYC};
      acc_sum = 48'(st.ramp_acc + {32'h0, RATED_RPM});
   end

   // bus, power latch, run state, position and speed paths
   always_comb begin
      next_st         = st;
      next_st.pwr_m   = power_good_in;
      next_st.pwr_s   = st.pwr_m;
      next_st.pwr_d   = st.pwr_s;
      next_st.pulse_m = cmd_pulse_in;
      next_st.pulse_s = st.pulse_m;
      next_st.pulse_d = st.pulse_s;
      next_st.dir_m   = cmd_dir_in;
      next_st.dir_s   = st.dir_m;
      drp             = st.droop;

      // write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.waddr   = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wstrb  = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_held && st.w_held) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = `SRS_RESP_OKAY;
         case (st.waddr)
            `SRS_IDX_MODE:  next_st.mode_pend = merge16(st.mode_pend, st.wdata, st.wstrb); // RL15
            `SRS_IDX_FUNC:  next_st.func_pend = merge16(st.func_pend, st.wdata, st.wstrb); // RL15
            `SRS_IDX_TUNE:  next_st.tune      = merge16(st.tune, st.wdata, st.wstrb);
            `SRS_IDX_SPD1:  next_st.spd1      = merge16(st.spd1, st.wdata, st.wstrb);
            `SRS_IDX_SPD2:  next_st.spd2      = merge16(st.spd2, st.wdata, st.wstrb);
            `SRS_IDX_SPD3:  next_st.spd3      = merge16(st.spd3, st.wdata, st.wstrb);
            `SRS_IDX_ACC:   next_st.acc_tc    = merge16(st.acc_tc, st.wdata, st.wstrb);
            `SRS_IDX_DEC:   next_st.dec_tc    = merge16(st.dec_tc, st.wdata, st.wstrb);
            `SRS_IDX_SCRV:  next_st.scrv_tc   = merge16(st.scrv_tc, st.wdata, st.wstrb);
            `SRS_IDX_STAT, `SRS_IDX_DROOP, `SRS_IDX_SPEED: next_st.bresp = `SRS_RESP_OKAY;
            default:        next_st.bresp     = `SRS_RESP_SLVERR;
         endcase
      end

      // read answers one cycle after the address is taken
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `SRS_RESP_OKAY;
         case (s_axi_araddr[7:2])
            `SRS_IDX_MODE:  next_st.rdata = {16'h0, st.mode_pend};
            `SRS_IDX_FUNC:  next_st.rdata = {16'h0, st.func_pend};
            `SRS_IDX_TUNE:  next_st.rdata = {16'h0, st.tune};
            `SRS_IDX_SPD1:  next_st.rdata = {16'h0, st.spd1};
            `SRS_IDX_SPD2:  next_st.rdata = {16'h0, st.spd2};
            `SRS_IDX_SPD3:  next_st.rdata = {16'h0, st.spd3};
            `SRS_IDX_ACC:   next_st.rdata = {16'h0, st.acc_tc};
            `SRS_IDX_DEC:   next_st.rdata = {16'h0, st.dec_tc};
            `SRS_IDX_SCRV:  next_st.rdata = {16'h0, st.scrv_tc};
            `SRS_IDX_STAT:  next_st.rdata = {18'h0, st.pwr_s, st.disp_value, !in.emergency_halt,
                                             speed_mode, 2'(st.run), filt_vec};
            `SRS_IDX_DROOP: next_st.rdata = {{16{st.droop[15]}}, st.droop};
            `SRS_IDX_SPEED: next_st.rdata = {{16{st.speed[15]}}, st.speed};
            default: begin
               next_st.rdata = 32'h0;
               next_st.rresp = `SRS_RESP_SLVERR;
            end
         endcase
      end

      // mode and function settings are taken only when power comes up
      if (pwr_rise) begin
         next_st.mode_act = st.mode_pend; // RL15 RL19
         next_st.func_act = st.func_pend; // RL15 RL16
      end

      // stop priority: power, then alarm or emergency, then servo-on
      if (!st.pwr_s) begin
         next_st.run = SRS_UNPOWERED; // RL2
      end else if (alarm_in || !in.emergency_halt) begin
         next_st.run = SRS_BRAKED; // RL6 RL7 RL20
      end else if (!in.servo_enable) begin
         next_st.run = SRS_COAST; // RL5
      end else begin
         next_st.run = SRS_LOCKED; // RL1
      end

      // position mode: accumulate pulses, drain by motor steps
      next_st.step = 1'b0;
      if (st.run == SRS_LOCKED && !speed_mode) begin
         if (st.pulse_s && !st.pulse_d && (st.dir_s ? fwd_ok : rev_ok)) begin
            drp = st.dir_s ? 16'(drp + 16'sh1) : 16'(drp - 16'sh1); // RL4
         end
         if ((!fwd_ok && drp > 0) || (!rev_ok && drp < 0)) begin
            drp = 16'sh0; // RL8
         end
         if (!st.step && drp != 0) begin
            next_st.step     = 1'b1;
            next_st.step_dir = (drp > 0);
            drp              = (drp > 0) ? 16'(drp - 16'sh1) : 16'(drp + 16'sh1);
         end
      end else begin
         drp = 16'sh0;
      end
      next_st.droop = drp;

      // speed mode: ramp towards the target
      if (st.run == SRS_LOCKED && speed_mode) begin
         if (tc == 16'h0 || st.speed == target) begin
            next_st.speed    = target; // RL11
            next_st.ramp_acc = 48'h0;
         end else if (acc_sum >= thr) begin
            next_st.ramp_acc = 48'(acc_sum - thr); // RL14
            next_st.speed    = (st.speed < target) ? 16'(st.speed + 16'sh1) : 16'(st.speed - 16'sh1);
         end else begin
            next_st.ramp_acc = acc_sum;
         end
      end else begin
         next_st.speed    = 16'sh0;
         next_st.ramp_acc = 48'h0;
      end

      // display: symbol at power-up, value two seconds on
      if (!st.pwr_s || pwr_rise) begin
         next_st.disp_cnt   = 32'h0;
         next_st.disp_value = 1'b0;
      end else if (!st.disp_value) begin
         if (st.disp_cnt == 32'(DISP_CYC - 32'h1)) begin
            next_st.disp_value = 1'b1; // RL17
         end else begin
            next_st.disp_cnt = 32'(st.disp_cnt + 32'h1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st           <= '0;
         st.run       <= SRS_UNPOWERED;
         st.mode_pend <= `SRS_RST_MODE;
         st.func_pend <= `SRS_RST_FUNC;
         st.mode_act  <= `SRS_RST_MODE;
         st.func_act  <= `SRS_RST_FUNC;
         st.tune      <= `SRS_RST_TUNE;
         st.spd1      <= `SRS_RST_SPD1;
         st.spd2      <= `SRS_RST_SPD2;
         st.spd3      <= `SRS_RST_SPD3;
         st.acc_tc    <= `SRS_RST_ACC;
         st.dec_tc    <= `SRS_RST_DEC;
         st.scrv_tc   <= `SRS_RST_SCRV;
      end else begin
         st <= next_st;
      end
   end

   // bus handshakes and outputs
   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready  = !st.w_held && !st.bvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rresp   = st.rresp;
   assign s_axi_rdata   = st.rdata;

   assign drive.base_on       = (st.run == SRS_LOCKED);
   assign drive.dyn_brake     = (st.run == SRS_BRAKED); // RL6 RL7
   assign drive.servo_lock    = (st.run == SRS_LOCKED); // RL1
   assign drive.brake_release = (st.run == SRS_LOCKED);
   assign brake_interlock_out = (st.run == SRS_LOCKED);
   assign halt_warning_code   = st.pwr_d && (st.run == SRS_BRAKED) && !in.emergency_halt; // RL7
   assign motor_step          = st.step;
   assign motor_dir           = st.step_dir;
   assign speed_cmd           = st.speed;
   assign tune_level          = st.tune[`SRS_TUNE_LVL_MSB:`SRS_TUNE_LVL_LSB]; // RL18
   assign tune_active         = (st.run == SRS_LOCKED); // RL18
   assign display_speed_symbol = speed_mode;
   assign display_show_value  = st.disp_value;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_power_up;
      !st.pwr_d ##0 st.pwr_s;
   endsequence

   sequence s_ready_cond;
      st.pwr_s && in.servo_enable && in.emergency_halt && !alarm_in;
   endsequence

   chk_ready_lock: assert property (s_ready_cond |=> drive.servo_lock && !drive.dyn_brake) // RL1
      else $error("servo-on did not lock the motor");
   chk_coast_stop: assert property (st.pwr_s && !in.servo_enable && in.emergency_halt && !alarm_in
                                    |=> !drive.base_on && !drive.dyn_brake) // RL5
      else $error("servo-off did not coast");
   chk_alarm_brake: assert property (st.pwr_s && alarm_in |=> drive.dyn_brake && !drive.base_on) // RL6
      else $error("alarm did not brake");
   chk_halt_warning: assert property (st.pwr_s && st.pwr_d && !in.emergency_halt ##1 !in.emergency_halt
                                      |-> halt_warning_code && drive.dyn_brake) // RL7
      else $error("emergency stop without warning");
   chk_droop_clear: assert property (st.run == SRS_LOCKED && !speed_mode && !fwd_ok |=> st.droop <= 0) // RL8
      else $error("error count kept towards limit");
   chk_limit_sudden: assert property (st.run == SRS_LOCKED && speed_mode && !fwd_ok && st.speed > 0
                                      && $stable(st.run) |=> st.speed <= 0) // RL9
      else $error("speed not stopped at limit");
   chk_decel_ramp: assert property (st.run == SRS_LOCKED && speed_mode && in.fwd_run == in.rev_run
                                    && fwd_ok && rev_ok && st.speed > 0 && st.dec_tc != 16'h0 ##1
                                    st.run == SRS_LOCKED |-> st.speed >= 16'($past(st.speed) - 16'sh1)
                                    && st.speed <= $past(st.speed)) // RL10
      else $error("stop not ramped");
   chk_fwd_ccw: assert property (st.run == SRS_LOCKED && speed_mode && in.fwd_run && !in.rev_run && fwd_ok
                                 && pick_mag != 15'h0 && st.acc_tc == 16'h0 && st.dec_tc == 16'h0
                                 ##1 st.run == SRS_LOCKED |-> st.speed > 0) // RL12
      else $error("forward start not counter-clockwise");
   chk_mode_hold: assert property (!pwr_rise |=> $stable(st.mode_act) && $stable(st.func_act)) // RL19
      else $error("mode changed without power cycle");
   chk_mode_latch: assert property (s_power_up |=> st.mode_act == $past(st.mode_pend)) // RL15
      else $error("mode not taken at power-up");
   chk_disp_symbol: assert property (s_power_up |=> !st.disp_value [*8]) // RL17
      else $error("display value shown too early");

endmodule // srs_sequencer

`default_nettype wire

// ---- srs_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// host controller: switches power on, then closes the servo-on contact
module srs_ctl_model
   import srs_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         pwr_req,
   input  wire srs_inputs_t  req,
   output logic             power_good_in,
   output srs_inputs_t      pins
);
   // servo-on contact closes only once power has stood a cycle
   always_ff @(posedge aclk) begin
      power_good_in <= pwr_req;
      pins <= srs_inputs_t'({req.servo_enable & power_good_in & pwr_req, req[6:0]});
   end
endmodule // srs_ctl_model
`default_nettype wire

// ---- servo_run_stop_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module servo_run_stop_sequencer_bench;
   import srs_pkg::*;
   logic        aclk = 0, aresetn = 0, pwr = 0, pg, alarm = 0, awv = 0, wv = 0, arv = 0;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, rdv;
   logic [1:0]  br, rr, resp;
   logic        awrdy, wrdy, bv, arrdy, rv, bil, warn, step, mdir, tact, dsym, dval;
   logic [15:0] spd;
   logic [3:0]  tl;
   logic        pls = 0, cdir = 1, bready = 0, rready = 0;
   logic [7:0]  nstep;
   srs_drive_t  drv;
   srs_inputs_t req = '0, pin;
   int          fail_count = 0, n_checks = 0, cyc = 0;
   // rows: alarm, pins, {base_on, dyn_brake, warning}, speed
   logic [27:0] rows [11] = '{
      {1'b0, 8'b1111_1001, 3'b100, 16'd100},
      {1'b0, 8'b1111_0110, 3'b100, 16'hfe0c},
      {1'b0, 8'b1111_1011, 3'b100, 16'd1000},
      {1'b0, 8'b1111_1111, 3'b100, 16'd0},
      {1'b0, 8'b1111_0011, 3'b100, 16'd0},
      {1'b0, 8'b1011_1011, 3'b100, 16'd0},
      {1'b0, 8'b1011_0110, 3'b100, 16'hfe0c},
      {1'b0, 8'b1101_0110, 3'b100, 16'd0},
      {1'b0, 8'b1010_1001, 3'b011, 16'd0},
      {1'b1, 8'b1111_1001, 3'b010, 16'd0},
      {1'b0, 8'b0111_1001, 3'b000, 16'd0}};
   logic [7:0]  ra [8] = '{8'h04, 8'h08, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
   logic [15:0] rx [8] = '{16'h0002, 16'h0105, 16'd100, 16'd500, 16'd1000, 16'h0, 16'h0, 16'h0};

   srs_sequencer #(.FILT_CYC(24'd4), .MS_CYC(32'd2), .DISP_CYC(32'd16)) srs_sequencer_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .power_good_in(pg), .servo_enable_in(pin.servo_enable),
      .fwd_travel_limit_in(pin.fwd_travel_limit), .rev_travel_limit_in(pin.rev_travel_limit),
      .emergency_halt_in(pin.emergency_halt), .fwd_run_in(pin.fwd_run), .rev_run_in(pin.rev_run),
      .speed_pick_bit0(pin.speed_pick0), .speed_pick_bit1(pin.speed_pick1), .cmd_pulse_in(pls),
      .cmd_dir_in(cdir), .alarm_in(alarm), .drive(drv), .brake_interlock_out(bil),
      .halt_warning_code(warn), .motor_step(step), .motor_dir(mdir), .speed_cmd(spd),
      .tune_level(tl), .tune_active(tact), .display_speed_symbol(dsym), .display_show_value(dval));
   srs_ctl_model srs_ctl_model_inst (.aclk(aclk), .pwr_req(pwr), .req(req), .power_good_in(pg), .pins(pin));

   // clock and hang guard
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict;
      end
   end

   task give_verdict;
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask

   // bus write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a; wd <= d; awv <= 1; wv <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awrdy) awv <= 0;
         if (wrdy) wv <= 0;
      end while (!bv);
      resp = br;
      bready <= 0;
      @(posedge aclk);
   endtask

   // bus read: held until taken, data picked up with the answer
   task rd(input logic [7:0] a);
      ara <= a; arv <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arrdy) arv <= 0;
      end while (!rv);
      resp = rr; rdv = rdat;
      rready <= 0;
      @(posedge aclk);
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      // speed mode is only pending until power comes up
      wr(8'h00, 32'h1);
      repeat (4) @(posedge aclk);
      chk(dsym, 0, "symbol early");
      pwr <= 1;
      repeat (10) @(posedge aclk);
      chk(dsym, 1, "symbol");
      chk(dval, 0, "value early");
      repeat (30) @(posedge aclk);
      chk(dval, 1, "value");
      wr(8'h08, 32'h0103);
      repeat (3) @(posedge aclk);
      chk(tl, 3, "tune level");
      // stop patterns and speeds, one row each
      for (int i = 0; i < 11; i++) begin
         req <= srs_inputs_t'(rows[i][26:19]); alarm <= rows[i][27];
         repeat (20) @(posedge aclk);
         chk({drv, warn, spd, bil, tact}, {rows[i][18:17], rows[i][18], rows[i][18], rows[i][16:0], rows[i][18],
             rows[i][18]}, $sformatf("row %0d", i));
      end
      // ramped stop: a deceleration constant makes the speed fall step by step
      wr(8'h30, 32'h1);
      req <= srs_inputs_t'(rows[0][26:19]);
      repeat (20) @(posedge aclk);
      req <= srs_inputs_t'(rows[4][26:19]);
      repeat (20) @(posedge aclk);
      chk(spd > 16'd70 && spd < 16'd100, 1, "ramp under way");
      repeat (100) @(posedge aclk);
      chk(spd, 0, "ramp end");
      // second reset mid-run
      aresetn <= 0;
      repeat (4) @(posedge aclk);
      chk({drv, spd, tl, awrdy}, {4'h0, 16'h0, 4'h5, 1'b1}, "reset outputs");
      aresetn <= 1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         rd(ra[i]);
         chk(rdv, {16'h0, rx[i]}, $sformatf("reset reg %h", ra[i]));
      end
      // unmapped and read-only places
      rd(8'h3c);
      chk({resp, rdv}, {2'h2, 32'h0}, "unmapped read");
      wr(8'hfc, 32'h1);
      chk(resp, 2'h2, "unmapped write");
      wr(8'h40, 32'hffff);
      chk(resp, 2'h0, "read-only write");
      // position mode after reset: pulses give steps, none towards an open limit
      for (int k = 0; k < 3; k++) begin
         req <= srs_inputs_t'(rows[k ? 5 : 0][26:19]);
         cdir <= (k != 2);
         nstep = 0;
         repeat (20) @(posedge aclk);
         for (int j = 0; j < 24; j++) begin
            pls <= (j < 6) && j[0];
            @(posedge aclk);
            nstep += step;
         end
         chk({nstep, mdir}, {(k == 1) ? 8'd0 : 8'd3, k != 2}, "pulse steps");
      end
      give_verdict;
   end
endmodule // servo_run_stop_sequencer_bench
`default_nettype wire
